// >>> verilog/sccg_clock_gate.sv
// Secondary clock gating control with clock-run policy and capability registers.
// Function
// R1: Slot 0 clock stops on code 11.
// R2: Slot 1 clock stops on code 11.
// R3: Slot 2 clock stops on code 11.
// R4: Slot 3 clock stops on code 11.
// R5: Bit 8 stops device 1 clock.
// R6: Bit 9 stops device 2 clock.
// R7: Bit 10 stops bridge feedback clock.
// R8: Enables act in forward bridge mode only.
// R9: Bit 13 reports secondary clock stopped.
// R10: Bit 14 enables clock-run protocol.
// R11: Mode 0 stops clock only in D3hot.
// R12: Mode 1 stops clock when bus idle. The code also needs no primary request pending.
// R13: Reserved control bits read zero.
// R14: Capability identifier 0Dh at A8h.
// R15: Next pointer B0h, or A0h with slot ID.
// R16: Subsystem vendor identifier, read-only, low half.
// R17: Subsystem identifier, read-only, upper half.
// R18: Express capability identifier 10h at B0h.
// R19: Power-state code 11 means D3.
// R20: Reverse mode stores enables without gating.
`timescale 1ns/1ps
`include "sccg_cfg.svh"
`default_nettype none
module sccg_clock_gate
   import sccg_pkg::*;
#(
   parameter logic [15:0] CARD_VENDOR_ID = 16'h0000, // Arbitrary value.
   parameter logic [15:0] CARD_ID        = 16'h0000  // Arbitrary value.
)
(
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Register port.
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Bridge status, all asynchronous to clk.
   input  wire logic        forward_mode,
   input  wire logic [1:0]  power_state,
   input  wire logic        secondary_bus_idle,
   input  wire logic        primary_request_pending,
   input  wire logic        slot_id_enable,
   // Secondary clock source, sampled as an ordinary input.
   input  wire logic        secondary_clock_in,
   // Gated secondary clock outputs.
   output logic             slot0_clock_out,
   output logic             slot1_clock_out,
   output logic             slot2_clock_out,
   output logic             slot3_clock_out,
   output logic             device1_clock_out,
   output logic             device2_clock_out,
   output logic             bridge_feedback_clock_out
);

   // Bit positions of each pin inside the synchroniser vectors.
   localparam int NSYNC     = 7;
   localparam int IX_FWD    = 0;
   localparam int IX_PWR    = 1;
   localparam int IX_IDLE   = 3;
   localparam int IX_PEND   = 4;
   localparam int IX_SLOTID = 5;
   localparam int IX_SCLK   = 6;
   // Number of gated clock outputs.
   localparam int NOUT      = 7;
   // Reset image of the control register, sliced per field below.
   localparam logic [31:0] CTRL_RST = `SCCG_CTRL_RST;

   // Synchroniser input and output vectors.
   logic [NSYNC-1:0] pins_raw;
   logic [NSYNC-1:0] pins_sync;
   // Synchronised status levels.
   logic             fwd_s;
   logic [1:0]       pwr_s;
   logic             d3_s;
   logic             idle_s;
   logic             pend_s;
   logic             slotid_s;
   logic             sclk_s;
   // Stored control fields.
   logic [7:0]       slot_codes_r;
   logic [1:0]       dev_off_r;
   logic             bridge_off_r;
   logic             clkrun_en_r;
   logic             clkrun_mode_r;
   // Clock-run policy.
   logic             ctrl_wr;
   logic             stop_ok;
   logic             stop_req;
   logic             close_all;
   logic             stopped;
   sccg_state_t      state_r;
   // Gating.
   logic [NOUT-1:0]  field_run;
   logic [NOUT-1:0]  gate_nxt;
   logic [NOUT-1:0]  out_vec;
   // Read path.
   logic [31:0]      ctrl_word;
   logic [31:0]      rdata_nxt;

   // A slot field stops its clock only on the one off code; the other three run.
   function automatic logic slot_runs(input logic [1:0] code);
      return code != `SCCG_SLOT_OFF_CODE;
   endfunction

   // Address match of a strobe against one register offset.
   function automatic logic addr_hit
   (
      input logic       strobe,
      input logic [7:0] a,
      input logic [7:0] ofs
   );
      return strobe && (a == ofs);
   endfunction

   // Pins gathered in one vector; each bit gets its own two-flop synchroniser.
   assign pins_raw = {secondary_clock_in, slot_id_enable, primary_request_pending,
                      secondary_bus_idle, power_state, forward_mode};

   for (genvar i = 0; i < NSYNC; i++)
   begin : g_sync
      logic meta_r;
      logic hold_r;

      // Nothing but the second flop reads the first, so no logic sees metastability.
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
         begin
            meta_r <= 1'b0;
            hold_r <= 1'b0;
         end
         else
         begin
            meta_r <= pins_raw[i];
            hold_r <= meta_r;
         end
      end

      assign pins_sync[i] = hold_r;
   end

   // Named views of the synchronised pins.
   assign fwd_s    = pins_sync[IX_FWD];
   assign pwr_s    = pins_sync[IX_PWR +: 2];
   assign idle_s   = pins_sync[IX_IDLE];
   assign pend_s   = pins_sync[IX_PEND];
   assign slotid_s = pins_sync[IX_SLOTID];
   assign sclk_s   = pins_sync[IX_SCLK];

   // The power bits cross one by one; a move between D0 and D3 can only pass
   // through the unimplemented codes, so a false D3 never shows for a cycle.
   assign d3_s = (pwr_s == `SCCG_PWR_D3); // R19

   // One strobe decode serves every control field below.
   assign ctrl_wr = addr_hit(reg_wr, reg_addr, `SCCG_OFS_CLK_CTRL);

   // Slot clock fields; all four codes are stored, in reverse mode as well.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         slot_codes_r <= CTRL_RST[`SCCG_SLOT0_LSB +: 8];
      else if (ctrl_wr)
         slot_codes_r <= reg_wdata[`SCCG_SLOT0_LSB +: 8]; // R20
   end

   // Device clock disable bits.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         dev_off_r <= CTRL_RST[`SCCG_DEV2_BIT:`SCCG_DEV1_BIT];
      else if (ctrl_wr)
         dev_off_r <= reg_wdata[`SCCG_DEV2_BIT:`SCCG_DEV1_BIT]; // R20
   end

   // Bridge feedback clock disable bit.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         bridge_off_r <= CTRL_RST[`SCCG_BRIDGE_BIT];
      else if (ctrl_wr)
         bridge_off_r <= reg_wdata[`SCCG_BRIDGE_BIT]; // R20
   end

   // Clock-run enable; off after reset, so the secondary clock always starts running.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         clkrun_en_r <= CTRL_RST[`SCCG_CLKRUN_EN_BIT];
      else if (ctrl_wr)
         clkrun_en_r <= reg_wdata[`SCCG_CLKRUN_EN_BIT]; // R10
   end

   // Clock-run mode select.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         clkrun_mode_r <= CTRL_RST[`SCCG_CLKRUN_MODE_BIT];
      else if (ctrl_wr)
         clkrun_mode_r <= reg_wdata[`SCCG_CLKRUN_MODE_BIT];
   end

   // Stop condition depends on mode: D3hot only, or idle bus with no primary request.
   always_comb
   begin
      if (clkrun_mode_r)
         stop_ok = idle_s && !pend_s; // R12
      else
         stop_ok = d3_s; // R11
   end

   // A stop is wanted only while the protocol is enabled.
   assign stop_req = clkrun_en_r && stop_ok; // R10

   // Gates close at the very edge that enters the stopped state, so the status bit
   // never reports a stop while an output can still make a pulse.
   assign close_all = (state_r == SCCG_STOPPED) || ((state_r == SCCG_STOPPING) && stop_req);

   // Stop sequencing waits for a low phase so the clock never ends on a runt pulse.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state_r <= SCCG_RUN;
      else
      begin
         case (state_r)
            SCCG_RUN:
               if (stop_req) // R10
                  state_r <= SCCG_STOPPING;
            SCCG_STOPPING:
               if (!stop_req)
                  state_r <= SCCG_RUN;
               else if (!sclk_s)
                  state_r <= SCCG_STOPPED;
            SCCG_STOPPED:
               if (!stop_req)
                  state_r <= SCCG_RUN;
            default:
               state_r <= SCCG_RUN;
         endcase
      end
   end

   // Status seen by software.
   assign stopped = (state_r == SCCG_STOPPED); // R9

   // Enables from the control fields, before mode and clock-run are applied.
   always_comb
   begin
      field_run[0] = slot_runs(slot_codes_r[`SCCG_SLOT0_LSB +: 2]); // R1
      field_run[1] = slot_runs(slot_codes_r[`SCCG_SLOT1_LSB +: 2]); // R2
      field_run[2] = slot_runs(slot_codes_r[`SCCG_SLOT2_LSB +: 2]); // R3
      field_run[3] = slot_runs(slot_codes_r[`SCCG_SLOT3_LSB +: 2]); // R4
      field_run[4] = !dev_off_r[0]; // R5
      field_run[5] = !dev_off_r[1]; // R6
      field_run[6] = !bridge_off_r; // R7
   end

   for (genvar i = 0; i < NOUT; i++)
   begin : g_out
      logic gate_r;
      logic pin_r;

      // Reverse mode opens the gate; a clock-run stop closes it in either mode.
      assign gate_nxt[i] = (field_run[i] || !fwd_s) && !close_all; // R8 R20

      // The gate moves only while the sampled clock is low, so no pulse is cut short.
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
            gate_r <= 1'b1;
         else if (!sclk_s)
            gate_r <= gate_nxt[i];
      end

      // Output flop; a closed gate holds the pin low.
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
            pin_r <= 1'b0;
         else
            pin_r <= sclk_s & gate_r;
      end

      assign out_vec[i] = pin_r;
   end

   // Output pins straight from the output flops.
   assign slot0_clock_out           = out_vec[0];
   assign slot1_clock_out           = out_vec[1];
   assign slot2_clock_out           = out_vec[2];
   assign slot3_clock_out           = out_vec[3];
   assign device1_clock_out         = out_vec[4];
   assign device2_clock_out         = out_vec[5];
   assign bridge_feedback_clock_out = out_vec[6];

   // Control word as read back; reserved bits stay zero.
   always_comb
   begin
      ctrl_word                                = 32'h00000000; // R13
      ctrl_word[`SCCG_SLOT0_LSB +: 8]          = slot_codes_r;
      ctrl_word[`SCCG_DEV2_BIT:`SCCG_DEV1_BIT] = dev_off_r;
      ctrl_word[`SCCG_BRIDGE_BIT]              = bridge_off_r;
      ctrl_word[`SCCG_STOPPED_BIT]             = stopped; // R9
      ctrl_word[`SCCG_CLKRUN_EN_BIT]           = clkrun_en_r;
      ctrl_word[`SCCG_CLKRUN_MODE_BIT]         = clkrun_mode_r;
   end

   // Read decode; unmapped addresses return zero.
   always_comb
   begin
      rdata_nxt = 32'h00000000;
      case (reg_addr)
         `SCCG_OFS_CLK_CTRL:
         begin
            rdata_nxt = ctrl_word; // R9 R13
         end
         `SCCG_OFS_SUBSYS_CAP:
            rdata_nxt = {16'h0000,
                         slotid_s ? `SCCG_NEXT_SLOT_ID : `SCCG_NEXT_DEFAULT, // R15
                         `SCCG_CAP_ID_SUBSYS}; // R14
         `SCCG_OFS_CARD_ID:
            rdata_nxt = {CARD_ID, CARD_VENDOR_ID}; // R16 R17
         `SCCG_OFS_EXP_CAP:
            rdata_nxt = {24'h000000, `SCCG_CAP_ID_EXPRESS}; // R18
         default:
            rdata_nxt = 32'h00000000;
      endcase
   end

   // Read data stands in the cycle after the strobe only.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
         reg_rdata <= rdata_nxt;
      else
         reg_rdata <= 32'h00000000;
   end

endmodule // sccg_clock_gate
`default_nettype wire

// >>> verilog/sccg_cfg.svh
// Register offsets, field positions and reset values of the secondary clock gating block.
`ifndef SCCG_CFG_SVH
`define SCCG_CFG_SVH
`define SCCG_OFS_CLK_CTRL   8'ha4
`define SCCG_OFS_SUBSYS_CAP 8'ha8
`define SCCG_OFS_CARD_ID    8'hac
`define SCCG_OFS_EXP_CAP    8'hb0
`define SCCG_SLOT0_LSB      0
`define SCCG_SLOT1_LSB      2
`define SCCG_SLOT2_LSB      4
`define SCCG_SLOT3_LSB      6
`define SCCG_DEV1_BIT       8
`define SCCG_DEV2_BIT       9
`define SCCG_BRIDGE_BIT     10
`define SCCG_STOPPED_BIT    13
`define SCCG_CLKRUN_EN_BIT  14
`define SCCG_CLKRUN_MODE_BIT 15
`define SCCG_CTRL_WR_MASK   32'h0000c7ff
`define SCCG_CTRL_RST       32'h00000000
`define SCCG_SLOT_OFF_CODE  2'h3
`define SCCG_CAP_ID_SUBSYS  8'h0d
`define SCCG_NEXT_DEFAULT   8'hb0
`define SCCG_NEXT_SLOT_ID   8'ha0
`define SCCG_CAP_ID_EXPRESS 8'h10
`define SCCG_PWR_D3         2'h3
`endif

// >>> verilog/sccg_pkg.sv
// Types shared by the secondary clock gating block.
package sccg_pkg;
   typedef enum logic [1:0]
   {
      SCCG_RUN      = 2'b00,
      SCCG_STOPPING = 2'b01,
      SCCG_STOPPED  = 2'b10
   } sccg_state_t;
endpackage

// >>> sim/sccg_chk.sv
// Property checker for the clock gating block.
`timescale 1ns/1ps
`default_nettype none
module sccg_chk
(
   // Clock and reset.
   input wire logic        clk,
   input wire logic        rst_n,
   // Register port.
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Clock path.
   input wire logic        secondary_clock_in,
   input wire logic        slot0_clock_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Read answers are judged against the address taken one cycle earlier.
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data not zero");
   a_cap_ident: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha8 |->
      reg_rdata[7:0] == 8'h0d && reg_rdata[31:16] == 16'h0) else $error("bad cap id");
   a_next_ptr: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha8 |->
      reg_rdata[15:8] inside {8'hb0, 8'ha0}) else $error("bad next pointer");
   // The bench keeps the default card identifiers, both zero.
   a_card_word: assert property ($past(reg_rd) && $past(reg_addr) == 8'hac |->
      reg_rdata == 32'h0) else $error("bad card ids");
   a_express_ident: assert property ($past(reg_rd) && $past(reg_addr) == 8'hb0 |->
      reg_rdata == 32'h10) else $error("bad express id");
   a_ctrl_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha4 |->
      reg_rdata[31:16] == 16'h0 && reg_rdata[12:11] == 2'h0) else $error("reserved set");
   a_stopped_low: assert property ($past(reg_rd) && $past(reg_addr) == 8'ha4
      && reg_rdata[13] |-> ##1 !slot0_clock_out) else $error("clock runs while stopped");
   // An output high must come from a high source sample through the synchroniser.
   a_out_source: assert property (slot0_clock_out |-> $past(secondary_clock_in, 3)
      || $past(secondary_clock_in, 4)) else $error("output not from source");
   c_stopped: cover property ($past(reg_rd) && reg_rdata[13]);
   c_slot_next: cover property ($past(reg_rd) && reg_rdata[15:8] == 8'ha0);
   c_out_rise: cover property ($rose(slot0_clock_out));
endmodule // sccg_chk
`default_nettype wire

// >>> sim/sccg_bus_model.sv
// Secondary bus model: free clock source and edge counters at the slots, devices and bridge feedback.
`timescale 1ns/1ps
`default_nettype none
module sccg_bus_model
(
   // Clock towards the bridge.
   output var logic       sec_clk,
   // Gated clocks at the slots and devices.
   input  wire logic [6:0] clk_pins,
   output int             edges [7]
);
   // The bus clock runs free; an odd start keeps it out of phase with clk.
   initial
   begin
      sec_clk = 1'b0;
      #1.3;
      forever #40 sec_clk = ~sec_clk;
   end
   for (genvar i = 0; i < 7; i++)
   begin : g_cnt
      initial edges[i] = 0;
      always @(posedge clk_pins[i]) edges[i] = edges[i] + 1;
   end
endmodule // sccg_bus_model
`default_nettype wire

// >>> sim/sccg_clock_gate_tb.sv
// Self-checking bench for the clock gating block.
`timescale 1ns/1ps
`default_nettype none
module sccg_clock_gate_tb;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  addr = 8'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        wr = 1'b0, rd = 1'b0, fwd = 1'b1, idle = 1'b0, pend = 1'b0, sid = 1'b0;
   logic [1:0]  pwr = 2'h0;
   logic        sclk;
   logic [6:0]  outs;
   int          edges [7], snap [7], err_total = 0, tests_run = 0;
   always #2 clk = ~clk;
   sccg_clock_gate i_dut
   (
      .clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
      .reg_rd(rd), .reg_rdata(rdata), .forward_mode(fwd), .power_state(pwr),
      .secondary_bus_idle(idle), .primary_request_pending(pend), .slot_id_enable(sid),
      .secondary_clock_in(sclk), .slot0_clock_out(outs[0]), .slot1_clock_out(outs[1]),
      .slot2_clock_out(outs[2]), .slot3_clock_out(outs[3]), .device1_clock_out(outs[4]),
      .device2_clock_out(outs[5]), .bridge_feedback_clock_out(outs[6])
   );
   sccg_bus_model i_bus (.sec_clk(sclk), .clk_pins(outs), .edges(edges));
   task automatic check(input logic [31:0] seen, exp, input string what);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(rdata, exp, what);
      // Return on a rising edge so that later stimulus lands on the edge too.
      @(posedge clk);
   endtask
   // Settle past the synchroniser and low-phase wait, then count edges.
   task automatic gates(input logic [6:0] stop, input string what);
      repeat (40) @(posedge clk);
      snap = edges;
      repeat (100) @(posedge clk);
      for (int i = 0; i < 7; i++)
         check(32'(edges[i] == snap[i]), 32'(stop[i]), what);
   endtask
   task automatic t_regs;
      rchk(8'ha4, 32'h0, "ctrl");
      rchk(8'ha8, 32'h0000b00d, "cap");
      rchk(8'hac, 32'h0, "ids");
      rchk(8'h00, 32'h0, "unmapped");
      wr32(8'ha4, 32'hffffffff);
      rchk(8'ha4, 32'h0000c7ff, "mask");
      wr32(8'hb0, 32'hffffffff);
      rchk(8'hb0, 32'h10, "exp");
      sid <= 1'b1;
      repeat (4) @(posedge clk);
      rchk(8'ha8, 32'h0000a00d, "next");
      $display("regs done");
   endtask
   task automatic t_gate;
      logic [31:0] v [9] = '{'h3, 'hc, 'h30, 'hc0, 'h100, 'h200, 'h400, 'h55, 'haa};
      logic [6:0]  m [9] = '{'h1, 'h2, 'h4, 'h8, 'h10, 'h20, 'h40, 'h0, 'h0};
      for (int k = 0; k < 9; k++)
      begin
         wr32(8'ha4, v[k]);
         gates(m[k], "gate");
      end
      fwd <= 1'b0;
      wr32(8'ha4, 32'h7ff);
      gates(7'h0, "rev");
      rchk(8'ha4, 32'h7ff, "rev");
      fwd <= 1'b1;
      gates(7'h7f, "fwd");
      $display("gate done");
   endtask
   task automatic t_run;
      wr32(8'ha4, 32'h0);
      pwr <= 2'h3;
      gates(7'h0, "off");
      wr32(8'ha4, 32'h4000);
      gates(7'h7f, "d3");
      rchk(8'ha4, 32'h6000, "stat");
      pwr <= 2'h0;
      idle <= 1'b1;
      gates(7'h0, "d0");
      rchk(8'ha4, 32'h4000, "stat");
      wr32(8'ha4, 32'hc000);
      gates(7'h7f, "idle");
      pend <= 1'b1;
      gates(7'h0, "pend");
      $display("run done");
   endtask
   task automatic end_sim;
      $display("compares %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_gate();
      t_run();
      end_sim();
   end
   // Watchdog, about five times the expected run.
   initial
   begin
      #50000;
      err_total++;
      end_sim();
   end
endmodule // sccg_clock_gate_tb
bind sccg_clock_gate sccg_chk i_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .secondary_clock_in(secondary_clock_in),
   .slot0_clock_out(slot0_clock_out));
`default_nettype wire
